// File: pkg/dac_pkg.sv
package dac_pkg;

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] DAC_OFS_CURSOR = 8'h04;
   localparam logic [7:0] DAC_OFS_LIMIT  = 8'h08;
   localparam logic [7:0] DAC_OFS_DEV    = 8'h0C;
   localparam logic [7:0] DAC_OFS_CTRL   = 8'h10;
   localparam logic [7:0] DAC_OFS_ISTS   = 8'h14;
   localparam logic [7:0] DAC_OFS_IMSK   = 8'h18;

   localparam logic [31:0] DAC_PTR_RST   = 32'h0000_0000;
   localparam logic [31:0] DAC_ZERO_WORD = 32'h0000_0000;

   // -------------------------------------------------------------
   // Control register fields
   // -------------------------------------------------------------
   localparam int DAC_CTL_ABORT  = 25;
   localparam int DAC_CTL_GO     = 24;
   localparam int DAC_CTL_SZ_HI  = 22;
   localparam int DAC_CTL_SZ_LO  = 20;
   localparam int DAC_CTL_HWDIS  = 19;
   localparam int DAC_CTL_INCDEV = 17;
   localparam int DAC_CTL_INCMEM = 16;
   localparam int DAC_CTL_BUSY   = 5;
   localparam int DAC_CTL_DONE   = 2;
   localparam int DAC_CTL_RUN    = 0;

   localparam logic [2:0] DAC_SIZE_RST = 3'h0;

   // -------------------------------------------------------------
   // Interrupt status / mask fields
   // -------------------------------------------------------------
   localparam int DAC_IRQ_W     = 2;
   localparam int DAC_IRQ_DONE  = 0;
   localparam int DAC_IRQ_ABORT = 1;
   localparam logic [DAC_IRQ_W-1:0] DAC_IRQ_RST = 2'h0;

   // -------------------------------------------------------------
   // Channel sequencer
   // -------------------------------------------------------------
   typedef enum logic [1:0]
   {
      DAC_IDLE  = 2'b00,
      DAC_WAIT  = 2'b01,
      DAC_MOVE  = 2'b10,
      DAC_CHECK = 2'b11
   } dac_state_t;

endpackage

// File: sim/dac_far_model.sv
`timescale 1ns/1ps

// -------------------------------------------------------------
// Far side: memory slave that ends packets and a paced peripheral
// -------------------------------------------------------------
module dac_far_model
   import dac_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        pkt_req,
   output logic             pkt_ack,
   input  wire logic [31:0] dev_addr,
   output logic             fc_req,
   input  wire logic        fc_ack,
   input  wire logic        fc_kick,
   input  wire logic        slow,
   output logic      [31:0] pkt_cnt,
   output logic      [31:0] ack_cnt,
   output logic      [31:0] last_dev
);
   logic [3:0] wait_q;

   // Slow mode stretches each packet so the channel must hold its request
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wait_q   <= 4'h0;
         pkt_ack  <= 1'b0;
         pkt_cnt  <= 32'h0;
         last_dev <= 32'h0;
      end
      else
      begin
         pkt_ack <= 1'b0;
         if (pkt_req && !pkt_ack)
         begin
            if (wait_q >= (slow ? 4'h4 : 4'h0))
            begin
               pkt_ack  <= 1'b1;
               wait_q   <= 4'h0;
               pkt_cnt  <= pkt_cnt + 32'h1;
               last_dev <= dev_addr;
            end
            else
               wait_q <= wait_q + 4'h1;
         end
      end
   end

   // Request is a level held until the channel reports the packet done
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         fc_req  <= 1'b0;
         ack_cnt <= 32'h0;
      end
      else
      begin
         if (fc_kick)
            fc_req <= 1'b1;
         else if (fc_ack)
            fc_req <= 1'b0;
         if (fc_ack)
            ack_cnt <= ack_cnt + 32'h1;
      end
   end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps

module tb_top
   import dac_pkg::*;
;
   logic        mclk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fc_req;
   logic        fc_ack;
   logic        pkt_req;
   logic        pkt_ack;
   logic [31:0] mem_addr;
   logic [31:0] dev_addr;
   logic [2:0]  pkt_size;
   logic        irq;
   logic        fc_kick;
   logic        slow;
   logic [31:0] pkt_cnt;
   logic [31:0] ack_cnt;
   logic [31:0] last_dev;
   logic [31:0] rd;
   logic [31:0] base;
   logic [31:0] sz;
   logic        er;
   int          error_cnt;
   int          comparisons;
   int          i;

   dac_channel dac_channel_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fc_req(fc_req), .fc_ack(fc_ack), .pkt_req(pkt_req),
      .pkt_ack(pkt_ack), .mem_addr(mem_addr), .dev_addr(dev_addr), .pkt_size(pkt_size),
      .irq(irq));

   dac_far_model dac_far_model_i (.mclk(mclk), .rst_n(rst_n), .pkt_req(pkt_req),
      .pkt_ack(pkt_ack), .dev_addr(dev_addr), .fc_req(fc_req), .fc_ack(fc_ack),
      .fc_kick(fc_kick), .slow(slow), .pkt_cnt(pkt_cnt), .ack_cnt(ack_cnt),
      .last_dev(last_dev));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // -------------------------------------------------------------
   // Checking and bus tasks
   // -------------------------------------------------------------
   task automatic wrap_up;
      begin
         $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
         if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         comparisons++;
         if (got !== exp)
         begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   // Request held until pready is seen at a rising edge; the answer is looked
   // at mid-cycle, where it is settled, and is the value that the next edge samples
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge mclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge mclk);
         penable <= 1'b1;
         n = 0;
         @(negedge mclk);
         while (pready !== 1'b1 && n < 20)
         begin
            @(negedge mclk);
            n++;
         end
         rd = prdata;
         er = pslverr;
         @(posedge mclk);
         psel    <= 1'b0;
         penable <= 1'b0;
         if (n >= 20)
         begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, exp, rd);
      end
   endtask

   // Bounded poll for the done flag
   task automatic wait_done;
      int n;
      begin
         n = 0;
         do
         begin
            apb(1'b0, DAC_OFS_CTRL, 32'h0);
            n++;
         end
         while (rd[DAC_CTL_DONE] !== 1'b1 && n < 50);
         if (n >= 50)
         begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask

   function automatic logic [31:0] ctl(input logic g, input logic h, input logic id,
                                       input logic im, input logic [2:0] s);
      ctl = 32'h1 << DAC_CTL_RUN;
      ctl[DAC_CTL_GO] = g;
      ctl[DAC_CTL_HWDIS] = h;
      ctl[DAC_CTL_INCDEV] = id;
      ctl[DAC_CTL_INCMEM] = im;
      ctl[DAC_CTL_SZ_HI:DAC_CTL_SZ_LO] = s;
   endfunction

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      error_cnt = 0;
      comparisons = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fc_kick = 1'b0;
      slow = 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rdc("limit reset", DAC_OFS_LIMIT, 32'h0);
      rdc("device reset", DAC_OFS_DEV, 32'h0);
      rdc("control reset", DAC_OFS_CTRL, 32'h0);
      rdc("unmapped data", 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      // Firmware-paced runs for every legal size, limit two packets away
      for (i = 0; i < 3; i++)
      begin
         sz = 32'h1 << i;
         slow <= i[0];
         apb(1'b1, DAC_OFS_CURSOR, 32'h100);
         apb(1'b1, DAC_OFS_LIMIT, 32'h100 + (sz << 1));
         apb(1'b1, DAC_OFS_DEV, 32'h2000);
         apb(1'b1, DAC_OFS_ISTS, 32'h3);
         base = pkt_cnt;
         apb(1'b1, DAC_OFS_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b1, sz[2:0]));
         wait_done();
         chk("packets", 32'h2, pkt_cnt - base);
         chk("busy", 32'h0, {31'h0, rd[DAC_CTL_BUSY]});
         rdc("cursor", DAC_OFS_CURSOR, 32'h100 + (sz << 1));
         rdc("device", DAC_OFS_DEV, 32'h2000 + (sz << 1));
         chk("device bus addr", 32'h2000 + sz, last_dev);
         chk("pkt_size", sz, {29'h0, pkt_size});
         rdc("status", DAC_OFS_ISTS, 32'h1);
      end
      // Status stays hidden until unmasked
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, DAC_OFS_IMSK, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, DAC_OFS_ISTS, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // Cursor already equals limit, yet no stepping means no end
      apb(1'b1, DAC_OFS_CURSOR, 32'h40);
      apb(1'b1, DAC_OFS_LIMIT, 32'h40);
      apb(1'b1, DAC_OFS_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b0, 3'h1));
      repeat (40) @(posedge mclk);
      rdc("running", DAC_OFS_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 3'h1) | 32'h20);
      chk("cursor held", 32'h40, mem_addr);
      apb(1'b1, DAC_OFS_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 3'h1) | 32'h0200_0000);
      apb(1'b0, DAC_OFS_CTRL, 32'h0);
      chk("busy after abort", 32'h0, {31'h0, rd[DAC_CTL_BUSY]});
      chk("pkt_req after abort", 32'h0, {31'h0, pkt_req});
      rdc("abort status", DAC_OFS_ISTS, 32'h2);
      // Peripheral request held while pacing is disabled, served once enabled
      apb(1'b1, DAC_OFS_ISTS, 32'h3);
      apb(1'b1, DAC_OFS_CURSOR, 32'h10);
      apb(1'b1, DAC_OFS_LIMIT, 32'h11);
      apb(1'b1, DAC_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 3'h1));
      base = pkt_cnt;
      @(posedge mclk);
      fc_kick <= 1'b1;
      @(posedge mclk);
      fc_kick <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("ignored packets", 32'h0, pkt_cnt - base);
      apb(1'b1, DAC_OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 3'h1));
      wait_done();
      chk("paced packets", 32'h1, pkt_cnt - base);
      chk("fc_ack pulses", 32'h1, ack_cnt);
      rdc("paced cursor", DAC_OFS_CURSOR, 32'h11);
      wrap_up();
   end
endmodule

// File: src/dac_channel.sv
`timescale 1ns/1ps

module dac_channel
   import dac_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fc_req,
   output logic             fc_ack,
   output logic             pkt_req,
   input  wire logic        pkt_ack,
   output logic      [31:0] mem_addr,
   output logic      [31:0] dev_addr,
   output logic      [2:0]  pkt_size,
   output logic             irq
);

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   dac_state_t           state_q;
   logic [31:0]          limit_q;
   logic                 abort_q;
   logic                 go_q;
   logic [2:0]           size_q;
   logic                 hwdis_q;
   logic                 incdev_q;
   logic                 incmem_q;
   logic                 run_q;
   logic                 done_q;
   logic [DAC_IRQ_W-1:0] ists_q;
   logic [DAC_IRQ_W-1:0] imsk_q;
   logic                 wr_acc;
   logic                 rd_acc;
   logic                 wr_cursor;
   logic                 wr_dev;
   logic                 pkt_done;
   logic                 fw_start;
   logic                 hw_start;
   logic                 hit_limit;
   logic                 end_evt;
   logic                 mapped;
   logic [31:0]          ctrl_rd;
   logic [31:0]          rd_d;

   // -------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------
   // Two-cycle access phase: pready rises on the second cycle, and writes
   // take effect only at the edge that samples it high.
   assign wr_acc    = psel && penable && pready && pwrite;
   assign rd_acc    = psel && penable && !pready && !pwrite;
   assign wr_cursor = wr_acc && (paddr == DAC_OFS_CURSOR);
   assign wr_dev    = wr_acc && (paddr == DAC_OFS_DEV);

   always_comb
   begin
      ctrl_rd = DAC_ZERO_WORD;
      ctrl_rd[DAC_CTL_ABORT]               = abort_q;
      ctrl_rd[DAC_CTL_GO]                  = go_q;
      ctrl_rd[DAC_CTL_SZ_HI:DAC_CTL_SZ_LO] = size_q;
      ctrl_rd[DAC_CTL_HWDIS]               = hwdis_q;
      ctrl_rd[DAC_CTL_INCDEV]              = incdev_q;
      ctrl_rd[DAC_CTL_INCMEM]              = incmem_q;
      ctrl_rd[DAC_CTL_BUSY]                = (state_q != DAC_IDLE);
      ctrl_rd[DAC_CTL_DONE]                = done_q;
      ctrl_rd[DAC_CTL_RUN]                 = run_q;
   end

   always_comb
   begin
      mapped = 1'b1;
      rd_d   = DAC_ZERO_WORD;
      if (paddr == DAC_OFS_CURSOR)
      begin
         rd_d = mem_addr;
      end
      else if (paddr == DAC_OFS_LIMIT)
      begin
         rd_d = limit_q;
      end
      else if (paddr == DAC_OFS_DEV)
      begin
         rd_d = dev_addr;
      end
      else if (paddr == DAC_OFS_CTRL)
      begin
         rd_d = ctrl_rd;
      end
      else if (paddr == DAC_OFS_ISTS)
      begin
         rd_d[DAC_IRQ_W-1:0] = ists_q;
      end
      else if (paddr == DAC_OFS_IMSK)
      begin
         rd_d[DAC_IRQ_W-1:0] = imsk_q;
      end
      else
      begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= DAC_ZERO_WORD;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (rd_acc)
         begin
            prdata <= rd_d;
         end
      end
   end

   // -------------------------------------------------------------
   // Limit and control registers
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         limit_q  <= DAC_PTR_RST;
         size_q   <= DAC_SIZE_RST;
         hwdis_q  <= 1'b0;
         incdev_q <= 1'b0;
         incmem_q <= 1'b0;
         run_q    <= 1'b0;
      end
      else if (wr_acc && (paddr == DAC_OFS_LIMIT))
      begin
         limit_q <= pwdata;
      end
      else if (wr_acc && (paddr == DAC_OFS_CTRL))
      begin
         size_q   <= pwdata[DAC_CTL_SZ_HI:DAC_CTL_SZ_LO];
         hwdis_q  <= pwdata[DAC_CTL_HWDIS];
         incdev_q <= pwdata[DAC_CTL_INCDEV];
         incmem_q <= pwdata[DAC_CTL_INCMEM];
         run_q    <= pwdata[DAC_CTL_RUN];
      end
   end

   // Abort and go act once and then clear, so a stale bit cannot restart
   // or kill a later transfer.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         abort_q <= 1'b0;
         go_q    <= 1'b0;
      end
      else
      begin
         if (wr_acc && (paddr == DAC_OFS_CTRL) && pwdata[DAC_CTL_ABORT])
         begin
            abort_q <= 1'b1;
         end
         else
         begin
            abort_q <= 1'b0;
         end
         if (wr_acc && (paddr == DAC_OFS_CTRL) && pwdata[DAC_CTL_GO])
         begin
            go_q <= 1'b1;
         end
         else if (fw_start || abort_q)
         begin
            go_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Channel sequencer
   // -------------------------------------------------------------
   assign pkt_done  = pkt_req && pkt_ack;
   assign fw_start  = (state_q == DAC_IDLE) && run_q && go_q && !abort_q;
   assign hw_start  = ((state_q == DAC_IDLE) || (state_q == DAC_WAIT)) && run_q
                      && !hwdis_q && fc_req && !abort_q && !go_q;
   assign hit_limit = incmem_q && (mem_addr == limit_q);
   assign end_evt   = (state_q == DAC_CHECK) && hit_limit && !abort_q;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_q <= DAC_IDLE;
      end
      else if (abort_q)
      begin
         state_q <= DAC_IDLE;
      end
      else
      begin
         case (state_q)
            DAC_IDLE:
            begin
               if (fw_start || hw_start)
               begin
                  state_q <= DAC_MOVE;
               end
            end
            DAC_WAIT:
            begin
               if (hw_start)
               begin
                  state_q <= DAC_MOVE;
               end
            end
            DAC_MOVE:
            begin
               if (pkt_ack)
               begin
                  state_q <= DAC_CHECK;
               end
            end
            DAC_CHECK:
            begin
               // Compare against the cursor already stepped by this packet
               if (hit_limit)
               begin
                  state_q <= DAC_IDLE;
               end
               else if (hwdis_q)
               begin
                  state_q <= DAC_MOVE;
               end
               else
               begin
                  state_q <= DAC_WAIT;
               end
            end
            default:
            begin
               state_q <= DAC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pkt_req  <= 1'b0;
         fc_ack   <= 1'b0;
         pkt_size <= DAC_SIZE_RST;
         done_q   <= 1'b0;
      end
      else
      begin
         pkt_req  <= !abort_q && !pkt_done && (fw_start || hw_start || (state_q == DAC_MOVE)
                     || ((state_q == DAC_CHECK) && !hit_limit && hwdis_q));
         fc_ack   <= pkt_done && !hwdis_q;
         pkt_size <= size_q;
         if (end_evt)
         begin
            done_q <= 1'b1;
         end
         else if (fw_start || hw_start)
         begin
            done_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Pointers
   // -------------------------------------------------------------
   dac_ptr_step u_cursor
   (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .wr_en   (wr_cursor),
      .wr_data (pwdata),
      .step_en (pkt_done && incmem_q),
      .step    (size_q),
      .ptr_q   (mem_addr)
   );

   // Device pointer drives the device-side bus address directly
   dac_ptr_step u_devptr
   (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .wr_en   (wr_dev),
      .wr_data (pwdata),
      .step_en (pkt_done && incdev_q),
      .step    (size_q),
      .ptr_q   (dev_addr)
   );

   // -------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ists_q <= DAC_IRQ_RST;
         imsk_q <= DAC_IRQ_RST;
         irq    <= 1'b0;
      end
      else
      begin
         // New events win over a write-one-to-clear in the same cycle
         if (wr_acc && (paddr == DAC_OFS_ISTS))
         begin
            ists_q <= ists_q & ~pwdata[DAC_IRQ_W-1:0];
         end
         if (end_evt)
         begin
            ists_q[DAC_IRQ_DONE] <= 1'b1;
         end
         if (abort_q && (state_q != DAC_IDLE))
         begin
            ists_q[DAC_IRQ_ABORT] <= 1'b1;
         end
         if (wr_acc && (paddr == DAC_OFS_IMSK))
         begin
            imsk_q <= pwdata[DAC_IRQ_W-1:0];
         end
         irq <= |(ists_q & imsk_q);
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_limit_end;
      end_evt |=> (state_q == DAC_IDLE) && done_q && ists_q[DAC_IRQ_DONE];
   endproperty
   a_limit_end: assert property (p_limit_end) else $error("limit hit did not end");

   property p_no_step_no_end;
      (state_q == DAC_CHECK) && !incmem_q && !abort_q |=> (state_q != DAC_IDLE);
   endproperty
   a_no_step_no_end: assert property (p_no_step_no_end) else $error("ended w/o step");

   property p_dev_addr_hold;
      pkt_req && !pkt_ack && !wr_dev |=> $stable(dev_addr);
   endproperty
   a_dev_addr_hold: assert property (p_dev_addr_hold) else $error("dev addr moved");

   property p_dev_step;
      pkt_done && incdev_q |=> dev_addr == $past(dev_addr) + {29'h0000_0000, $past(size_q)};
   endproperty
   a_dev_step: assert property (p_dev_step) else $error("dev pointer not stepped");

   property p_abort;
      abort_q |=> (state_q == DAC_IDLE) && !pkt_req && !abort_q;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not immediate");

   property p_fw_go;
      fw_start |=> (state_q == DAC_MOVE) && pkt_req && !go_q;
   endproperty
   a_fw_go: assert property (p_fw_go) else $error("go did not start");

   property p_size_out;
      pkt_req && $stable(size_q) |-> pkt_size == size_q;
   endproperty
   a_size_out: assert property (p_size_out) else $error("packet size mismatch");

   property p_mem_step;
      pkt_done && incmem_q |=> mem_addr == $past(mem_addr) + {29'h0000_0000, $past(size_q)};
   endproperty
   a_mem_step: assert property (p_mem_step) else $error("cursor not stepped");

   property p_fc_ignored;
      (state_q == DAC_IDLE) && hwdis_q && !go_q && fc_req |=> (state_q == DAC_IDLE);
   endproperty
   a_fc_ignored: assert property (p_fc_ignored) else $error("request not ignored");

   property p_check_after_step;
      $rose(done_q) |-> $past(state_q) == DAC_CHECK && $past(state_q, 2) == DAC_MOVE;
   endproperty
   a_check_after_step: assert property (p_check_after_step) else $error("early compare");

endmodule

// File: src/dac_ptr_step.sv
`timescale 1ns/1ps

// Pointer register that software loads and hardware steps per packet
module dac_ptr_step
   import dac_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic        step_en,
   input  wire logic [2:0]  step,
   output logic      [31:0] ptr_q
);

   // Hardware step wins over a software load in the same cycle, so a packet
   // that completes is never lost from the pointer.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ptr_q <= DAC_PTR_RST;
      end
      else if (step_en)
      begin
         ptr_q <= ptr_q + {29'h0000_0000, step};
      end
      else if (wr_en)
      begin
         ptr_q <= wr_data;
      end
   end

endmodule
